// [shared/ccrb_pkg.sv]
// Overview of operation
// R1: Alarm power-on flag sets on a detected power-on event; register resets to 01h.
// R2: Reading the alarm register clears it only when the cause has gone inactive.
// R3: Soft clear bit at 1 acts as hardware reset: I/O inputs, PCM output hi-Z.
// R4: Linear bit clear selects companded 8-bit coding; set selects 16-bit linear.
// R5: Companding law 0 is mu-law, all bits inverted; 1 is A-law, even bits.
// R6: Scan mode cycles four selects, each repeating every 31.25 us; else static I/O. Code uses 78-cycle slots, so 31.2 us.
// R7: Sleeping channel drives receive output to mid-supply and floats its transmit slot.
// R8: Command data goes to every enabled channel and to no disabled one.
// R9: Host sets at least one channel enable before every coefficient or channel command.
// R10: Memory-off bit at 1 disables coefficient RAM during power down; 0 keeps it.
// R11: Synchronisation check register always reads E4h.
// R12: Checksum done flag reads 0 while a checksum runs, 1 otherwise.
// R13: DSP ready flag rises once initialisation, about 70 us after reset, completes.
// R14: Checksum start sums all 16-bit coefficients; result at 26h/27h within 400 us.
// R15: Digital loopback routes received slot data to the transmit slot of that channel.
// R16: Analog loopback feeds the channel receive output back into its transmit input.
// R17: Looped signal also reaches receive output; digital gain 00h silences it.
// R18: Preamp bit 0 gives 0 dB, 1 gives 3.52 dB per channel.
// R19: Receive amp field 00 mute, 01 -12 dB, 10 -6 dB, 11 0 dB.
// R20: Five-bit current limit field programs 2 to 51.6 mA in 1.6 mA steps.
// R21: Four-bit off-hook threshold programs 1 to 16 mA in 1 mA steps.
// R22: Threshold enable bit switches the DC line-card programming block on or off.
// R23: Writes to read-only alarm, sync, status and checksum registers are ignored.
package ccrb_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CCRB_OFS_ALARM = 8'h14;
    localparam logic [7:0] CCRB_OFS_GLOBAL_CONFIG = 8'h20;
    localparam logic [7:0] CCRB_OFS_CMDEN = 8'h21;
    localparam logic [7:0] CCRB_OFS_SYNC = 8'h23;
    localparam logic [7:0] CCRB_OFS_STAT = 8'h25;
    localparam logic [7:0] CCRB_OFS_CKLO = 8'h26;
    localparam logic [7:0] CCRB_OFS_CKHI = 8'h27;
    localparam logic [7:0] CCRB_OFS_LOOP = 8'h2a;
    localparam logic [7:0] CCRB_OFS_TXG = 8'h2b;
    localparam logic [7:0] CCRB_OFS_RXG = 8'h2c;
    localparam logic [7:0] CCRB_OFS_LINE_CURRENT_LIMIT = 8'h2d;
    localparam logic [7:0] CCRB_OFS_ITH = 8'h2e;

    // ------------------------------------------------------------
    // Reset values and fixed codes
    // ------------------------------------------------------------
    localparam logic [7:0] CCRB_RST_ALARM = 8'h01;
    localparam logic [7:0] CCRB_RST_GLOBAL_CONFIG = 8'hbf;
    localparam logic [7:0] CCRB_RST_CMDEN = 8'h80;
    localparam logic [7:0] CCRB_RST_ZERO = 8'h00;
    localparam logic [7:0] CCRB_SYNC_CODE = 8'he4;
    localparam logic [7:0] CCRB_MU_INVERT = 8'hff;
    localparam logic [7:0] CCRB_A_INVERT = 8'h55;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CCRB_BIT_SOFT_CLEAR = 7;
    localparam int CCRB_BIT_LINEAR = 6;
    localparam int CCRB_BIT_LAW = 5;
    localparam int CCRB_BIT_STATIC = 4;
    localparam int CCRB_BIT_MEM_OFF = 7;
    localparam int CCRB_BIT_DC_EN = 4;
    localparam int CCRB_BIT_INIT = 1;
    localparam int CCRB_BIT_DONE = 0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CCRB_CLK_NS = 100;
    localparam int CCRB_INIT_NS = 70000;
    localparam int CCRB_INIT_CYCLES = (CCRB_INIT_NS + CCRB_CLK_NS - 1) / CCRB_CLK_NS;
    localparam int CCRB_SCAN_REP_NS = 31250;
    localparam int CCRB_SCAN_SLOT_CYCLES = CCRB_SCAN_REP_NS / (4 * CCRB_CLK_NS);
    localparam int CCRB_CHECKSUM_HIGH_MAX_NS = 400000;
    localparam int CCRB_CHECKSUM_HIGH_MAX_CYCLES = CCRB_CHECKSUM_HIGH_MAX_NS / CCRB_CLK_NS;
    localparam int CCRB_COEF_COUNT = 282;

    typedef enum logic [2:0] {
        CCRB_CK_IDLE = 3'b001,
        CCRB_CK_READ = 3'b010,
        CCRB_CK_ADD = 3'b100
    } ccrb_ck_state_t;

endpackage : ccrb_pkg

// [core/ccrb_top.sv]
`timescale 1ns/10ps
module ccrb_top
    import ccrb_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic por_cause,
    input wire logic checksum_begin_cmd,
    input wire logic cmd_data_strobe,
    input wire logic [15:0] coef_rd_data,
    output logic [8:0] coef_rd_addr,
    output logic line_io_force_input,
    output logic pcm_tx_out_hiz,
    output logic [3:0] select_out,
    output logic [3:0] select_oe,
    output logic linear_mode,
    output logic [7:0] code_invert_mask,
    output logic [3:0] rx_out_to_mid_supply_ref,
    output logic [3:0] tx_slot_hiz,
    output logic [3:0] cmd_apply,
    output logic [3:0] coef_ram_off,
    output logic [3:0] pcm_side_return,
    output logic [3:0] line_side_return,
    output logic [3:0] tx_preamp_boost,
    output logic [7:0] rx_amp_sel,
    output logic [4:0] line_current_code,
    output logic [3:0] offhook_code,
    output logic dc_prog_enable
);

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic alarm_reg;
    logic [7:0] global_config_reg;
    logic [7:0] cmden_reg;
    logic [7:0] loop_reg;
    logic [7:0] txg_reg;
    logic [7:0] rxg_reg;
    logic [7:0] line_current_limit_reg;
    logic [7:0] ith_reg;
    logic [15:0] checksum_high_reg;
    logic init_done_reg;
    logic [9:0] init_cnt_reg;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire logic wr_global_config = reg_wr && (reg_addr == CCRB_OFS_GLOBAL_CONFIG);
    wire logic wr_cmden = reg_wr && (reg_addr == CCRB_OFS_CMDEN);
    wire logic wr_loop = reg_wr && (reg_addr == CCRB_OFS_LOOP);
    wire logic wr_txg = reg_wr && (reg_addr == CCRB_OFS_TXG);
    wire logic wr_rxg = reg_wr && (reg_addr == CCRB_OFS_RXG);
    wire logic wr_line_current_limit = reg_wr && (reg_addr == CCRB_OFS_LINE_CURRENT_LIMIT);
    wire logic wr_ith = reg_wr && (reg_addr == CCRB_OFS_ITH); // R23
    wire logic rd_alarm = reg_rd && (reg_addr == CCRB_OFS_ALARM);

    wire logic soft_clear = global_config_reg[CCRB_BIT_SOFT_CLEAR];
    wire logic static_io = global_config_reg[CCRB_BIT_STATIC];
    wire logic [3:0] sleep = global_config_reg[3:0];
    wire logic [3:0] chan_mask = cmden_reg[3:0];
    wire logic mem_off = cmden_reg[CCRB_BIT_MEM_OFF];

    // ------------------------------------------------------------
    // Checksum engine
    // ------------------------------------------------------------
    ccrb_ck_state_t ck_state_reg;
    ccrb_ck_state_t ck_state_next;
    logic [15:0] ck_acc_reg;
    logic [8:0] ck_addr_reg;
    wire logic ck_busy = (ck_state_reg != CCRB_CK_IDLE);
    wire logic ck_last = (ck_addr_reg == 9'(CCRB_COEF_COUNT - 1));
    wire logic [15:0] ck_sum = ck_acc_reg + coef_rd_data;
    // Index drives memory directly, word arrives on the add cycle
    assign coef_rd_addr = ck_addr_reg; // R14

    always_comb begin
        ck_state_next = ck_state_reg;
        case (ck_state_reg)
            CCRB_CK_IDLE: begin
                if (checksum_begin_cmd) begin
                    ck_state_next = CCRB_CK_READ;
                end
            end
            CCRB_CK_READ: begin
                ck_state_next = CCRB_CK_ADD;
            end
            CCRB_CK_ADD: begin
                ck_state_next = ck_last ? CCRB_CK_IDLE : CCRB_CK_READ;
            end
            default: begin
                ck_state_next = CCRB_CK_IDLE;
            end
        endcase
        // A new start restarts a running sum
        if (checksum_begin_cmd) begin
            ck_state_next = CCRB_CK_READ; // R14
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ck_state_reg <= CCRB_CK_IDLE;
        end else begin
            ck_state_reg <= ck_state_next;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ck_acc_reg <= 16'h0000;
            ck_addr_reg <= 9'h000;
            checksum_high_reg <= 16'h0000;
        end else if (checksum_begin_cmd) begin
            ck_acc_reg <= 16'h0000;
            ck_addr_reg <= 9'h000;
        end else if (ck_state_reg == CCRB_CK_ADD) begin
            ck_acc_reg <= ck_sum; // R14
            ck_addr_reg <= ck_addr_reg + 9'h001;
            if (ck_last) begin
                checksum_high_reg <= ck_sum; // R14
            end
        end
    end

    // ------------------------------------------------------------
    // DSP initialisation timer
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            init_cnt_reg <= 10'h000;
            init_done_reg <= 1'b0;
        end else if (soft_clear) begin
            init_cnt_reg <= 10'h000; // R3
            init_done_reg <= 1'b0;
        end else if (!init_done_reg) begin
            init_cnt_reg <= init_cnt_reg + 10'h001;
            init_done_reg <= (init_cnt_reg == 10'(CCRB_INIT_CYCLES - 1)); // R13
        end
    end

    // ------------------------------------------------------------
    // Writable registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            global_config_reg <= CCRB_RST_GLOBAL_CONFIG;
            cmden_reg <= CCRB_RST_CMDEN;
            loop_reg <= CCRB_RST_ZERO;
            txg_reg <= CCRB_RST_ZERO;
            rxg_reg <= CCRB_RST_ZERO;
            line_current_limit_reg <= CCRB_RST_ZERO;
            ith_reg <= CCRB_RST_ZERO;
        end else begin
            if (wr_global_config) begin
                global_config_reg <= reg_wdata;
            end
            if (wr_cmden) begin
                cmden_reg <= {reg_wdata[7], 3'b000, reg_wdata[3:0]};
            end
            if (wr_loop) begin
                loop_reg <= reg_wdata;
            end
            if (wr_txg) begin
                txg_reg <= {4'h0, reg_wdata[3:0]};
            end
            if (wr_rxg) begin
                rxg_reg <= reg_wdata;
            end
            if (wr_line_current_limit) begin
                line_current_limit_reg <= {3'b000, reg_wdata[4:0]};
            end
            if (wr_ith) begin
                ith_reg <= {3'b000, reg_wdata[4:0]};
            end
        end
    end

    // ------------------------------------------------------------
    // Alarm flag
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            alarm_reg <= CCRB_RST_ALARM[0];
        end else if (por_cause) begin
            alarm_reg <= 1'b1; // R1 R2
        end else if (rd_alarm) begin
            alarm_reg <= 1'b0; // R2
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    logic [7:0] rd_mux;
    always_comb begin
        case (reg_addr)
            CCRB_OFS_ALARM: rd_mux = {7'h00, alarm_reg};
            CCRB_OFS_GLOBAL_CONFIG: rd_mux = global_config_reg;
            CCRB_OFS_CMDEN: rd_mux = cmden_reg;
            CCRB_OFS_SYNC: rd_mux = CCRB_SYNC_CODE; // R11
            CCRB_OFS_STAT: rd_mux = {6'h00, init_done_reg, !ck_busy}; // R12 R13
            CCRB_OFS_CKLO: rd_mux = checksum_high_reg[7:0];
            CCRB_OFS_CKHI: rd_mux = checksum_high_reg[15:8];
            CCRB_OFS_LOOP: rd_mux = loop_reg;
            CCRB_OFS_TXG: rd_mux = txg_reg;
            CCRB_OFS_RXG: rd_mux = rxg_reg;
            CCRB_OFS_LINE_CURRENT_LIMIT: rd_mux = line_current_limit_reg;
            CCRB_OFS_ITH: rd_mux = ith_reg;
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Select line scanner
    // ------------------------------------------------------------
    logic [6:0] scan_cnt_reg;
    logic [3:0] scan_sel_reg;
    wire logic scan_tick = (scan_cnt_reg == 7'(CCRB_SCAN_SLOT_CYCLES - 1));

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            scan_cnt_reg <= 7'h00;
            scan_sel_reg <= 4'h1;
        end else if (soft_clear || static_io) begin
            scan_cnt_reg <= 7'h00;
            scan_sel_reg <= 4'h1;
        end else if (scan_tick) begin
            scan_cnt_reg <= 7'h00;
            scan_sel_reg <= {scan_sel_reg[2:0], scan_sel_reg[3]}; // R6
        end else begin
            scan_cnt_reg <= scan_cnt_reg + 7'h01;
        end
    end

    // ------------------------------------------------------------
    // Derived control outputs
    // ------------------------------------------------------------
    wire logic [3:0] sel_oe_next = (soft_clear || static_io) ? 4'h0 : 4'hf; // R3 R6
    wire logic [7:0] inv_next = global_config_reg[CCRB_BIT_LAW] ? CCRB_A_INVERT : CCRB_MU_INVERT; // R5
    wire logic [3:0] ram_off_next = mem_off ? sleep : 4'h0; // R10
    wire logic [3:0] apply_next = cmd_data_strobe ? chan_mask : 4'h0; // R8

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            line_io_force_input <= 1'b1;
            pcm_tx_out_hiz <= 1'b1;
            select_out <= 4'h0;
            select_oe <= 4'h0;
            linear_mode <= 1'b0;
            code_invert_mask <= CCRB_MU_INVERT;
            rx_out_to_mid_supply_ref <= 4'h0;
            tx_slot_hiz <= 4'hf;
            cmd_apply <= 4'h0;
            coef_ram_off <= 4'h0;
        end else begin
            line_io_force_input <= soft_clear; // R3
            pcm_tx_out_hiz <= soft_clear; // R3
            select_out <= sel_oe_next & scan_sel_reg; // R6
            select_oe <= sel_oe_next;
            linear_mode <= global_config_reg[CCRB_BIT_LINEAR]; // R4
            code_invert_mask <= inv_next; // R5
            rx_out_to_mid_supply_ref <= sleep; // R7
            tx_slot_hiz <= sleep | {4{soft_clear}}; // R7
            cmd_apply <= apply_next; // R8
            coef_ram_off <= ram_off_next; // R10
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pcm_side_return <= 4'h0;
            line_side_return <= 4'h0;
            tx_preamp_boost <= 4'h0;
            rx_amp_sel <= 8'h00;
            line_current_code <= 5'h00;
            offhook_code <= 4'h0;
            dc_prog_enable <= 1'b0;
        end else begin
            pcm_side_return <= loop_reg[7:4]; // R15 R17
            line_side_return <= loop_reg[3:0]; // R16 R17
            tx_preamp_boost <= txg_reg[3:0]; // R18
            rx_amp_sel <= rxg_reg; // R19
            line_current_code <= line_current_limit_reg[4:0]; // R20
            offhook_code <= ith_reg[3:0]; // R21
            dc_prog_enable <= ith_reg[CCRB_BIT_DC_EN]; // R22
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    localparam int CKW = 1000;
    logic [12:0] ck_age_reg;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ck_age_reg <= 13'h0000;
        end else if (checksum_begin_cmd) begin
            ck_age_reg <= 13'h0001;
        end else if (ck_busy) begin
            ck_age_reg <= ck_age_reg + 13'h0001;
        end else begin
            ck_age_reg <= 13'h0000;
        end
    end

    a_alarm_set_por: assert property (por_cause |=> alarm_reg) // R1
        else $error("alarm flag not set by power-on cause");
    a_alarm_read_clr: assert property (rd_alarm && !por_cause |=> !alarm_reg) // R2
        else $error("alarm not cleared by read with cause inactive");
    a_soft_clear_io: assert property (soft_clear |=> pcm_tx_out_hiz && select_oe == 4'h0) // R3
        else $error("soft clear did not float outputs");
    a_law_mask: assert property (!global_config_reg[CCRB_BIT_LAW] |=> code_invert_mask == 8'hff) // R5
        else $error("mu-law mask wrong");
    a_scan_period: assert property (!soft_clear && !static_io && scan_tick && scan_sel_reg[0]
        |=> scan_sel_reg[1]) // R6
        else $error("scan did not advance");
    a_sleep_hiz: assert property (sleep[0] |=> tx_slot_hiz[0] && rx_out_to_mid_supply_ref[0]) // R7
        else $error("sleeping channel not parked");
    a_cmd_mask: assert property (cmd_data_strobe |=> cmd_apply == $past(chan_mask)) // R8
        else $error("command applied to wrong channels");
    a_sync_read: assert property (reg_rd && reg_addr == CCRB_OFS_SYNC |=> reg_rdata == 8'he4) // R11
        else $error("sync code wrong");
    a_done_flag: assert property (checksum_begin_cmd |=> ck_busy ##1 rd_mux[0] == 1'b0 || reg_addr != CCRB_OFS_STAT) // R12
        else $error("done flag high during checksum");
    a_init_time: assert property ($rose(init_done_reg) |-> $past(init_cnt_reg) == 10'(CCRB_INIT_CYCLES - 1)) // R13
        else $error("ready flag at wrong time");
    a_checksum_high_bound: assert property (ck_age_reg <= 13'(CCRB_CHECKSUM_HIGH_MAX_CYCLES)) // R14
        else $error("checksum exceeded time limit");
    a_ro_write: assert property (reg_wr && reg_addr == CCRB_OFS_CKLO && !ck_busy |=> $stable(checksum_high_reg)) // R23
        else $error("read-only register changed by write");
    a_alarm_hold: assert property (rd_alarm && por_cause |=> alarm_reg) // R2
        else $error("alarm cleared while cause active");
    a_tx_hiz_soft: assert property (soft_clear |=> tx_slot_hiz == 4'hf) // R3
        else $error("soft clear left a transmit slot driven");
    a_linear_mode: assert property (1'b1 |=> linear_mode == $past(global_config_reg[CCRB_BIT_LINEAR])) // R4
        else $error("linear coding output wrong");
    a_scan_off: assert property (soft_clear || static_io |=> select_out == 4'h0) // R6
        else $error("select lines scanning in static mode");
    a_ram_on: assert property (!mem_off |=> coef_ram_off == 4'h0) // R10
        else $error("coefficient memory off with memory-off bit clear");
    a_status_done: assert property (ck_busy && reg_rd && reg_addr == CCRB_OFS_STAT |=> !reg_rdata[0]) // R12
        else $error("done flag read high during checksum");
    a_rx_amp: assert property (1'b1 |=> rx_amp_sel == $past(rxg_reg)) // R19
        else $error("receive amp select wrong");
    a_dc_enable: assert property (1'b1 |=> dc_prog_enable == $past(ith_reg[CCRB_BIT_DC_EN])) // R22
        else $error("line-card programming enable wrong");
    a_cmd_idle: assert property (!cmd_data_strobe |=> cmd_apply == 4'h0) // R8
        else $error("command applied without strobe");

    c_alarm_clear: cover property (alarm_reg ##1 rd_alarm ##1 !alarm_reg);
    c_checksum_high_done: cover property (ck_busy ##[1:CKW] !ck_busy);
    c_scan_wrap: cover property (scan_tick && scan_sel_reg[3]);
    c_checksum_high_restart: cover property (ck_busy && checksum_begin_cmd);

endmodule : ccrb_top

// [test/ccrb_coef_mem.sv]
`timescale 1ns/10ps
module ccrb_coef_mem #(
    parameter logic [15:0] BASE = 16'h2b5d
) (
    input wire logic mclk,
    input wire logic [8:0] coef_rd_addr,
    output logic [15:0] coef_rd_data
);
    // ------------------------------------------------------------
    // Registered read, word valid the cycle after the index
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        coef_rd_data <= (16'(coef_rd_addr) * 16'h0133 + BASE) ^ {7'h00, coef_rd_addr};
    end
endmodule : ccrb_coef_mem

// [test/codec_control_register_bank_tb_top.sv]
`timescale 1ns/10ps
module codec_control_register_bank_tb_top;
    import ccrb_pkg::*;
    logic mclk, rst, reg_wr, reg_rd, por_cause, checksum_begin_cmd, cmd_data_strobe;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, code_invert_mask, rx_amp_sel, rd, s0;
    logic [15:0] coef_rd_data;
    logic [8:0] coef_rd_addr;
    logic line_io_force_input, pcm_tx_out_hiz, linear_mode, dc_prog_enable;
    logic [3:0] select_out, select_oe, rx_out_to_mid_supply_ref, tx_slot_hiz, cmd_apply, coef_ram_off;
    logic [3:0] pcm_side_return, line_side_return, tx_preamp_boost, offhook_code;
    logic [4:0] line_current_code;
    int fails, n_compared, seed, sum, k;
    int mdl[int];
    int rw_a[7] = '{'h20, 'h21, 'h2a, 'h2b, 'h2c, 'h2d, 'h2e};
    int rw_m[7] = '{'hff, 'h8f, 'hff, 'h0f, 'hff, 'h1f, 'h1f};
    int ro_a[5] = '{'h14, 'h23, 'h25, 'h26, 'h27};
    int modes[7] = '{'h00, 'h20, 'h40, 'h10, 'h0f, 'h80, 'h00};

    ccrb_top u_ccrb_top (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .por_cause(por_cause),
        .checksum_begin_cmd(checksum_begin_cmd), .cmd_data_strobe(cmd_data_strobe),
        .coef_rd_data(coef_rd_data), .coef_rd_addr(coef_rd_addr), .line_io_force_input(line_io_force_input),
        .pcm_tx_out_hiz(pcm_tx_out_hiz), .select_out(select_out), .select_oe(select_oe),
        .linear_mode(linear_mode), .code_invert_mask(code_invert_mask),
        .rx_out_to_mid_supply_ref(rx_out_to_mid_supply_ref), .tx_slot_hiz(tx_slot_hiz),
        .cmd_apply(cmd_apply), .coef_ram_off(coef_ram_off), .pcm_side_return(pcm_side_return),
        .line_side_return(line_side_return), .tx_preamp_boost(tx_preamp_boost), .rx_amp_sel(rx_amp_sel),
        .line_current_code(line_current_code), .offhook_code(offhook_code), .dc_prog_enable(dc_prog_enable));
    ccrb_coef_mem u_ccrb_coef_mem (.mclk(mclk), .coef_rd_addr(coef_rd_addr), .coef_rd_data(coef_rd_data));

    // ------------------------------------------------------------
    // Host side tasks and comparison
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc
    task automatic wr(input int a, input int d);
        @(posedge mclk);
        reg_addr <= 8'(a);
        reg_wdata <= 8'(d);
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rdr(input int a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= 8'(a);
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rdr
    task automatic rchk(input int a, input int e);
        rdr(a, rd);
        chk({8'h00, rd}, 16'(e & 'hff));
    endtask : rchk
    task automatic outs;
        logic [7:0] c;
        c = 8'(mdl['h20]);
        chk(16'(line_io_force_input), 16'(c[7]));
        chk(16'(pcm_tx_out_hiz), 16'(c[7]));
        chk(16'(linear_mode), 16'(c[6]));
        chk(16'(code_invert_mask), c[5] ? 16'h0055 : 16'h00ff);
        chk(16'(select_oe), (c[7] | c[4]) ? 16'h0000 : 16'h000f);
        chk(16'(rx_out_to_mid_supply_ref), 16'(c[3:0]));
        chk(16'(tx_slot_hiz), c[7] ? 16'h000f : 16'(c[3:0]));
        chk(16'(coef_ram_off), 16'(c[3:0] & {4{mdl['h21][7]}}));
        chk({pcm_side_return, line_side_return}, 16'(mdl['h2a]));
        chk(16'(tx_preamp_boost), 16'(mdl['h2b]));
        chk(16'(rx_amp_sel), 16'(mdl['h2c]));
        chk(16'(line_current_code), 16'(mdl['h2d]));
        chk({dc_prog_enable, offhook_code}, 16'(mdl['h2e]));
    endtask : outs
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        {reg_wr, reg_rd, por_cause, checksum_begin_cmd, cmd_data_strobe} = '0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        fails = 0;
        n_compared = 0;
        seed = 20392;
        mdl = '{'h14: 1, 'h20: 'hbf, 'h21: 'h80, 'h23: 'he4, 'h25: 1, 'h26: 0, 'h27: 0,
                'h2a: 0, 'h2b: 0, 'h2c: 0, 'h2d: 0, 'h2e: 0};
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        cyc(1);
        outs();
        foreach (mdl[a]) rchk(a, mdl[a]);
        mdl['h14] = 0;
        foreach (ro_a[i]) begin
            wr(ro_a[i], $random(seed));
            rchk(ro_a[i], mdl[ro_a[i]]);
        end
        wr('h22, 'hff);
        rchk('h22, 0);
        for (int n = 0; n < 6; n++) begin
            foreach (rw_a[i]) begin
                wr(rw_a[i], $random(seed));
                mdl[rw_a[i]] = reg_wdata & rw_m[i];
                rchk(rw_a[i], mdl[rw_a[i]]);
            end
            cyc(1);
            outs();
        end
        foreach (modes[i]) begin
            wr('h20, modes[i]);
            mdl['h20] = modes[i];
            cyc(2);
            outs();
        end
        rchk('h25, 1);
        cyc(700);
        rchk('h25, 3);
        s0 = select_out;
        chk(16'($countones(s0)), 16'h0001);
        cyc(156);
        chk(16'(select_out), 16'({s0[1:0], s0[3:2]}));
        cyc(156);
        chk(16'(select_out), 16'(s0));
        @(posedge mclk) por_cause <= 1'b1;
        cyc(2);
        rchk('h14, 1);
        rchk('h14, 1);
        @(posedge mclk) por_cause <= 1'b0;
        rchk('h14, 1);
        rchk('h14, 0);
        for (k = 1; k < 16; k++) begin
            wr('h21, k);
            @(posedge mclk) cmd_data_strobe <= 1'b1;
            @(posedge mclk) cmd_data_strobe <= 1'b0;
            #1 chk(16'(cmd_apply), 16'(k));
            cyc(1);
            chk(16'(cmd_apply), 16'h0000);
        end
        sum = 0;
        for (int i = 0; i < CCRB_COEF_COUNT; i++) sum += ((i * 307 + 'h2b5d) & 'hffff) ^ i;
        @(posedge mclk) checksum_begin_cmd <= 1'b1;
        @(posedge mclk) checksum_begin_cmd <= 1'b0;
        cyc(100);
        @(posedge mclk) checksum_begin_cmd <= 1'b1;
        @(posedge mclk) checksum_begin_cmd <= 1'b0;
        rchk('h25, 2);
        k = 2;
        rdr('h25, rd);
        while (rd[0] !== 1'b1 && k < CCRB_CHECKSUM_HIGH_MAX_CYCLES) begin
            rdr('h25, rd);
            k += 2;
        end
        chk(16'(rd[0]), 16'h0001);
        if (rd[0] !== 1'b1) wrap_up();
        rchk('h26, sum);
        rchk('h27, sum >> 8);
        rchk('h25, 3);
        wrap_up();
    end
endmodule : codec_control_register_bank_tb_top
